/* rtl/uus_pkg.sv */
// Package with register map, field layout and unit codes of unit scaling.
package uus_pkg;
	// ----------------------------------------------------------------
	// Register indices; the byte address is four times the index.
	// ----------------------------------------------------------------
	localparam int NCFG = 10; // Number of writable configuration words.
	localparam int CFG_POS = 0; // Position unit object.
	localparam int CFG_SPD = 1; // Speed unit object.
	localparam int CFG_ENCINC = 2; // Encoder increment count.
	localparam int CFG_ENCREV = 3; // Encoder motor revolution count.
	localparam int CFG_MOTREV = 4; // Motor shaft revolution count.
	localparam int CFG_DRVREV = 5; // Driving shaft revolution count.
	localparam int CFG_FEED = 6; // Feed amount.
	localparam int CFG_OUTREV = 7; // Output shaft revolution count.
	localparam int CFG_POLES = 8; // Pole pair count.
	localparam int CFG_CTRL = 9; // Control bits.
	localparam logic [15:0] CFG_IDX [NCFG] = '{16'h60a8, 16'h60a9,
		16'h6200, 16'h6201, 16'h6202, 16'h6203, 16'h6204, 16'h6205,
		16'h6206, 16'h6207};
	localparam logic [31:0] CFG_RST [NCFG] = '{32'hff410000, 32'h00b44700,
		32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001,
		32'h00000001, 32'h00000001, 32'h00000001, 32'h00000000};
	// Write masks force the reserved low bits of both unit words to zero.
	localparam logic [31:0] CFG_WMASK [NCFG] = '{32'hffff0000, 32'hffffff00,
		32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
		32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h00000003};
	localparam logic [15:0] IDX_STATUS = 16'h6210; // Status flags.
	localparam logic [15:0] IDX_ENCRES = 16'h6211; // Encoder resolution.
	localparam logic [15:0] IDX_GEAR = 16'h6212; // Effective gear ratio.
	localparam logic [15:0] IDX_FEEDC = 16'h6213; // Effective feed constant.
	localparam logic [15:0] IDX_UPR = 16'h6214; // Native units per rev.
	localparam logic [15:0] IDX_TSEC = 16'h6215; // Seconds per time unit.
	// ----------------------------------------------------------------
	// Field positions and control bits.
	// ----------------------------------------------------------------
	localparam int TIME_LSB = 8;
	localparam int UNIT_LSB = 16;
	localparam int EXP_LSB = 24;
	localparam int CTRL_OPENLOOP = 0; // Open-loop or sensorless control.
	localparam int CTRL_THREEPH = 1; // Three-phase brushless motor.
	// ----------------------------------------------------------------
	// Unit, time and exponent codes.
	// ----------------------------------------------------------------
	localparam logic [7:0] U_NONE = 8'h00, U_METER = 8'h01;
	localparam logic [7:0] U_INCH = 8'hc1, U_FOOT = 8'hc2;
	localparam logic [7:0] U_GRAD = 8'h40, U_RAD = 8'h10, U_DEG = 8'h41;
	localparam logic [7:0] U_AMIN = 8'h42, U_ASEC = 8'h43, U_REV = 8'hb4;
	localparam logic [7:0] U_INC = 8'hb5, U_STEP = 8'hac, U_POLE = 8'hc0;
	localparam logic [7:0] T_SEC = 8'h03, T_MIN = 8'h47, T_HOUR = 8'h48;
	localparam logic [7:0] T_DAY = 8'h49, T_YEAR = 8'h4a;
	localparam logic [31:0] SEC_SEC = 32'h00000001; // 1 s.
	localparam logic [31:0] SEC_MIN = 32'h0000003c; // 60 s.
	localparam logic [31:0] SEC_HOUR = 32'h00000e10; // 3600 s.
	localparam logic [31:0] SEC_DAY = 32'h00015180; // 86400 s.
	localparam logic [31:0] SEC_YEAR = 32'h01e187e0; // 365.25 days.
	localparam logic signed [7:0] EXP_MAX = 8'sh06; // Ten to the six.
	localparam logic signed [7:0] EXP_MIN = -8'sh06; // Coded as fa.
	localparam logic [31:0] STEP_2PH = 32'h00000004; // Steps per pole pair.
	localparam logic [31:0] STEP_3PH = 32'h00000006; // Steps per pole pair.
	localparam int INC_SHIFT = 16; // 65536 increments per pole pair.
	// ----------------------------------------------------------------
	// Ratio divider.
	// ----------------------------------------------------------------
	localparam int FRAC_BITS = 16; // Ratios are unsigned Q16.16.
	localparam logic [5:0] DIV_LAST = 6'h2f; // 48 quotient steps.
	localparam logic [31:0] ONE_Q16 = 32'h00010000;
	typedef enum logic {DIV_IDLE = 1'b0, DIV_RUN = 1'b1} uus_div_state_t;
endpackage : uus_pkg

/* rtl/uus_user_unit_scaling.sv */
// User unit scaling block with APB register access.
//
// The APB interface to the registers was chosen for this implementation.
module uus_user_unit_scaling (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic driveRunning,
	output logic useGear,
	output logic useFeed,
	output logic nativeUnit,
	output logic [31:0] unitsPerRev,
	output logic [31:0] timeSeconds,
	output logic [31:0] encResolution,
	output logic [31:0] gearRatio,
	output logic [31:0] feedConstant,
	output logic calcBusy
);
	// ----------------------------------------------------------------
	// Bus decode.
	// ----------------------------------------------------------------
	logic [31:0] pend_r [uus_pkg::NCFG]; // Words as written by software.
	logic [31:0] act_r [uus_pkg::NCFG]; // Words in force.
	logic [uus_pkg::NCFG-1:0] cfgHit; // Address hits a config word.
	logic [uus_pkg::NCFG-1:0] pendDiff; // Written word not yet in force.
	logic [31:0] readMux; // Read data for the addressed word.
	logic [31:0] prdata_r; // Read data captured in the setup cycle.
	logic [31:0] statusWord; // Flags assembled for reading.
	wire setupPhase = psel && !penable;
	wire accessPhase = psel && penable;
	wire apbWrite = accessPhase && pwrite;
	wire hitStatus = paddr == {14'h0000, uus_pkg::IDX_STATUS, 2'b00};
	wire hitEncRes = paddr == {14'h0000, uus_pkg::IDX_ENCRES, 2'b00};
	wire hitGear = paddr == {14'h0000, uus_pkg::IDX_GEAR, 2'b00};
	wire hitFeedC = paddr == {14'h0000, uus_pkg::IDX_FEEDC, 2'b00};
	wire hitUpr = paddr == {14'h0000, uus_pkg::IDX_UPR, 2'b00};
	wire hitTsec = paddr == {14'h0000, uus_pkg::IDX_TSEC, 2'b00};
	wire hitRo = hitStatus || hitEncRes || hitGear || hitFeedC || hitUpr ||
		hitTsec;
	wire mapped = (|cfgHit) || hitRo;
	// Writes to read-only words are refused as errors too.
	wire badAccess = !mapped || (hitRo && pwrite);

	// Zero wait states; unmapped or illegal accesses answer with pslverr.
	assign pready = accessPhase;
	assign pslverr = accessPhase && badAccess;
	assign prdata = prdata_r;

	// ----------------------------------------------------------------
	// Configuration words with deferred take-over.
	// ----------------------------------------------------------------
	genvar k;
	for (k = 0; k < uus_pkg::NCFG; k++) begin : g_cfg
		assign cfgHit[k] = paddr == {14'h0000, uus_pkg::CFG_IDX[k], 2'b00};
		assign pendDiff[k] = pend_r[k] != act_r[k];
		// Software copy; reserved bits are stored as zero.
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				pend_r[k] <= uus_pkg::CFG_RST[k];
			end else if (apbWrite && cfgHit[k]) begin
				pend_r[k] <= pwdata & uus_pkg::CFG_WMASK[k];
			end
		end
		// Copy in force follows only while the drive is not running.
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				act_r[k] <= uus_pkg::CFG_RST[k];
			end else if (!driveRunning) begin
				act_r[k] <= pend_r[k];
			end
		end
	end

	// A pending value is taken over in this cycle.
	wire applyEvt = !driveRunning && (|pendDiff);

	// ----------------------------------------------------------------
	// Field decode of the words in force.
	// ----------------------------------------------------------------
	wire [7:0] posCode = act_r[uus_pkg::CFG_POS][uus_pkg::UNIT_LSB +: 8];
	wire [7:0] posExp = act_r[uus_pkg::CFG_POS][uus_pkg::EXP_LSB +: 8];
	wire [7:0] spdCode = act_r[uus_pkg::CFG_SPD][uus_pkg::UNIT_LSB +: 8];
	wire [7:0] spdExp = act_r[uus_pkg::CFG_SPD][uus_pkg::EXP_LSB +: 8];
	wire [7:0] spdTime = act_r[uus_pkg::CFG_SPD][uus_pkg::TIME_LSB +: 8];
	wire [31:0] poles = act_r[uus_pkg::CFG_POLES];
	wire openLoop = act_r[uus_pkg::CFG_CTRL][uus_pkg::CTRL_OPENLOOP];
	wire threePhase = act_r[uus_pkg::CFG_CTRL][uus_pkg::CTRL_THREEPH];

	// Sorts a unit code into linear, angular or motor-native classes.
	function automatic logic [2:0] uus_unit_class(input logic [7:0] c);
		case (c)
			uus_pkg::U_NONE, uus_pkg::U_METER, uus_pkg::U_INCH,
			uus_pkg::U_FOOT: uus_unit_class = 3'b100;
			uus_pkg::U_GRAD, uus_pkg::U_RAD, uus_pkg::U_DEG, uus_pkg::U_AMIN,
			uus_pkg::U_ASEC, uus_pkg::U_REV: uus_unit_class = 3'b010;
			uus_pkg::U_INC, uus_pkg::U_STEP,
			uus_pkg::U_POLE: uus_unit_class = 3'b001;
			default: uus_unit_class = 3'b000;
		endcase
	endfunction : uus_unit_class

	// True for a power of ten between minus six and six.
	function automatic logic uus_exp_ok(input logic [7:0] e);
		uus_exp_ok = ($signed(e) <= uus_pkg::EXP_MAX) &&
			($signed(e) >= uus_pkg::EXP_MIN);
	endfunction : uus_exp_ok

	wire [2:0] posClass = uus_unit_class(posCode);
	wire [2:0] spdClass = uus_unit_class(spdCode);

	logic [31:0] timeSecNxt; // Seconds per speed time unit, zero if unknown.
	logic [31:0] uprNxt; // Native units per motor revolution.
	logic [31:0] encRes_r; // Encoder resolution, Q16.16.
	logic [31:0] gearRaw_r; // Gear ratio, Q16.16.
	logic [31:0] feedRaw_r; // Feed constant, Q16.16.

	// Decodes the time unit of the speed word.
	always_comb begin
		case (spdTime)
			uus_pkg::T_SEC: timeSecNxt = uus_pkg::SEC_SEC;
			uus_pkg::T_MIN: timeSecNxt = uus_pkg::SEC_MIN;
			uus_pkg::T_HOUR: timeSecNxt = uus_pkg::SEC_HOUR;
			uus_pkg::T_DAY: timeSecNxt = uus_pkg::SEC_DAY;
			uus_pkg::T_YEAR: timeSecNxt = uus_pkg::SEC_YEAR;
			default: timeSecNxt = 32'h00000000;
		endcase
	end

	// Size of one revolution in motor-native units.
	always_comb begin
		case (posCode)
			uus_pkg::U_INC: begin
				// Closed loop takes the whole part of the encoder resolution.
				if (openLoop) begin
					uprNxt = poles << uus_pkg::INC_SHIFT;
				end else begin
					uprNxt = {16'h0000, encRes_r[31:16]};
				end
			end
			uus_pkg::U_STEP: begin
				uprNxt = 32'(poles * (threePhase ? uus_pkg::STEP_3PH :
					uus_pkg::STEP_2PH));
			end
			uus_pkg::U_POLE: uprNxt = poles;
			default: uprNxt = 32'h00000000;
		endcase
	end

	logic useGear_r, useFeed_r, native_r; // Scaling selection flags.
	logic posOk_r, posExpOk_r, spdOk_r, spdExpOk_r, timeOk_r; // Code checks.
	logic [31:0] upr_r; // Registered native units per revolution.
	logic [31:0] tsec_r; // Registered seconds per time unit.
	logic [31:0] gear_r; // Gear ratio as applied.
	logic [31:0] feed_r; // Feed constant as applied.

	// Registers the decoded selection and checks.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			useGear_r <= 1'b0;
			useFeed_r <= 1'b0;
			native_r <= 1'b0;
			posOk_r <= 1'b0;
			posExpOk_r <= 1'b0;
			spdOk_r <= 1'b0;
			spdExpOk_r <= 1'b0;
			timeOk_r <= 1'b0;
			upr_r <= 32'h00000000;
			tsec_r <= 32'h00000000;
		end else begin
			useGear_r <= posClass[2] || posClass[1];
			useFeed_r <= posClass[2];
			native_r <= posClass[0];
			posOk_r <= |posClass;
			posExpOk_r <= uus_exp_ok(posExp);
			spdOk_r <= |spdClass;
			spdExpOk_r <= uus_exp_ok(spdExp);
			timeOk_r <= timeSecNxt != 32'h00000000;
			upr_r <= uprNxt;
			tsec_r <= timeSecNxt;
		end
	end

	// Gear and feed fall back to one when the unit does not use them.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gear_r <= uus_pkg::ONE_Q16;
			feed_r <= uus_pkg::ONE_Q16;
		end else begin
			gear_r <= useGear_r ? gearRaw_r : uus_pkg::ONE_Q16;
			feed_r <= useFeed_r ? feedRaw_r : uus_pkg::ONE_Q16;
		end
	end

	// ----------------------------------------------------------------
	// Shared ratio divider, one quotient bit per cycle.
	// ----------------------------------------------------------------
	uus_pkg::uus_div_state_t divState_r;
	logic recalc_r; // A new calculation is owed.
	logic [1:0] sel_r; // Ratio in work: resolution, gear, feed.
	logic [5:0] cnt_r; // Quotient step.
	logic [32:0] rem_r; // Partial remainder.
	logic [47:0] dvd_r; // Dividend shifting out at the top.
	logic [47:0] dvdOrig_r; // Dividend kept for checking.
	logic [47:0] quo_r; // Quotient shifting in at the bottom.
	logic [31:0] den_r; // Divisor of the ratio in work.
	wire [32:0] remShift = {rem_r[31:0], dvd_r[47]};
	wire remGe = remShift >= {1'b0, den_r};
	wire [47:0] quoFinal = {quo_r[46:0], remGe};
	wire divStart = divState_r == uus_pkg::DIV_IDLE && recalc_r;
	wire divDone = divState_r == uus_pkg::DIV_RUN && cnt_r == uus_pkg::DIV_LAST;
	// Zero divisor or overflow saturate to all ones.
	wire [31:0] ratioNxt = (den_r == 32'h00000000 || |quoFinal[47:32]) ?
		32'hffffffff : quoFinal[31:0];

	// Owed work is set on take-over; a set wins over the clear at start.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			recalc_r <= 1'b1;
		end else begin
			recalc_r <= applyEvt || (recalc_r && !divStart);
		end
	end

	// Steps the divider through the three ratios.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			divState_r <= uus_pkg::DIV_IDLE;
			sel_r <= 2'd0;
			cnt_r <= 6'd0;
		end else if (divStart) begin
			divState_r <= uus_pkg::DIV_RUN;
			sel_r <= 2'd0;
			cnt_r <= 6'd0;
		end else if (divDone) begin
			cnt_r <= 6'd0;
			sel_r <= sel_r + 2'd1;
			if (sel_r == 2'd2) begin
				divState_r <= uus_pkg::DIV_IDLE;
			end
		end else if (divState_r == uus_pkg::DIV_RUN) begin
			cnt_r <= cnt_r + 6'd1;
		end
	end

	// Loads operands at the first step of each ratio, then shifts.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rem_r <= 33'h000000000;
			dvd_r <= 48'h000000000000;
			dvdOrig_r <= 48'h000000000000;
			quo_r <= 48'h000000000000;
			den_r <= 32'h00000000;
		end else if (divStart || (divDone && sel_r != 2'd2)) begin
			rem_r <= 33'h000000000;
			dvd_r <= {(divStart ? act_r[uus_pkg::CFG_ENCINC] :
				act_r[uus_pkg::CFG_ENCINC + 2 * int'(sel_r + 2'd1)]), 16'h0000};
			dvdOrig_r <= {(divStart ? act_r[uus_pkg::CFG_ENCINC] :
				act_r[uus_pkg::CFG_ENCINC + 2 * int'(sel_r + 2'd1)]), 16'h0000};
			den_r <= divStart ? act_r[uus_pkg::CFG_ENCREV] :
				act_r[uus_pkg::CFG_ENCREV + 2 * int'(sel_r + 2'd1)];
			quo_r <= 48'h000000000000;
		end else if (divState_r == uus_pkg::DIV_RUN) begin
			rem_r <= remGe ? remShift - {1'b0, den_r} : remShift;
			dvd_r <= {dvd_r[46:0], 1'b0};
			quo_r <= quoFinal;
		end
	end

	// Stores each finished ratio.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			encRes_r <= uus_pkg::ONE_Q16;
			gearRaw_r <= uus_pkg::ONE_Q16;
			feedRaw_r <= uus_pkg::ONE_Q16;
		end else if (divDone) begin
			case (sel_r)
				2'd0: encRes_r <= ratioNxt;
				2'd1: gearRaw_r <= ratioNxt;
				default: feedRaw_r <= ratioNxt;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read path.
	// ----------------------------------------------------------------
	assign statusWord = {21'h000000, driveRunning, |pendDiff,
		divState_r == uus_pkg::DIV_RUN || recalc_r, spdExpOk_r, spdOk_r,
		timeOk_r, posExpOk_r, posOk_r, native_r, useFeed_r, useGear_r};

	// Selects the addressed word; unmapped addresses read zero.
	always_comb begin
		readMux = 32'h00000000;
		for (int i = 0; i < uus_pkg::NCFG; i++) begin
			if (cfgHit[i]) begin
				readMux = pend_r[i];
			end
		end
		if (hitStatus) readMux = statusWord;
		if (hitEncRes) readMux = encRes_r;
		if (hitGear) readMux = gear_r;
		if (hitFeedC) readMux = feed_r;
		if (hitUpr) readMux = upr_r;
		if (hitTsec) readMux = tsec_r;
	end

	// Captures read data in the setup cycle so it stands in the access.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r <= 32'h00000000;
		end else if (setupPhase && !pwrite) begin
			prdata_r <= readMux;
		end
	end

	assign useGear = useGear_r;
	assign useFeed = useFeed_r;
	assign nativeUnit = native_r;
	assign unitsPerRev = upr_r;
	assign timeSeconds = tsec_r;
	assign encResolution = encRes_r;
	assign gearRatio = gear_r;
	assign feedConstant = feed_r;
	assign calcBusy = divState_r == uus_pkg::DIV_RUN;

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	wire [63:0] prodChk = 64'(quoFinal) * 64'(den_r);

	a_defer_apply: assert property (@(posedge clock) disable iff (!rst_n)
		driveRunning |=> $stable(act_r[uus_pkg::CFG_POS]) &&
		$stable(act_r[uus_pkg::CFG_SPD]))
		else $error("unit word changed while drive running");
	a_pos_reserved: assert property (@(posedge clock) disable iff (!rst_n)
		apbWrite && cfgHit[uus_pkg::CFG_POS] |=>
		pend_r[uus_pkg::CFG_POS][15:0] == 16'h0000 &&
		pend_r[uus_pkg::CFG_POS][31:16] == $past(pwdata[31:16]))
		else $error("position word layout wrong");
	a_spd_reserved: assert property (@(posedge clock) disable iff (!rst_n)
		apbWrite && cfgHit[uus_pkg::CFG_SPD] |=>
		pend_r[uus_pkg::CFG_SPD][7:0] == 8'h00 &&
		pend_r[uus_pkg::CFG_SPD][31:8] == $past(pwdata[31:8]))
		else $error("speed word layout wrong");
	a_exp_range: assert property (@(posedge clock) disable iff (!rst_n)
		(posExp == 8'h07 || posExp == 8'hf9) |=> !posExpOk_r)
		else $error("exponent outside range accepted");
	a_linear_units: assert property (@(posedge clock) disable iff (!rst_n)
		(posCode == uus_pkg::U_INCH || posCode == uus_pkg::U_NONE) |=>
		useGear_r && useFeed_r) else $error("linear unit scaling wrong");
	a_angular_units: assert property (@(posedge clock) disable iff (!rst_n)
		posCode == uus_pkg::U_DEG |=> useGear_r && !useFeed_r ##1
		feed_r == uus_pkg::ONE_Q16) else $error("angular unit scaling wrong");
	a_native_units: assert property (@(posedge clock) disable iff (!rst_n)
		posCode == uus_pkg::U_STEP |=> native_r && !useGear_r && !useFeed_r)
		else $error("native unit scaling wrong");
	a_open_loop_rev: assert property (@(posedge clock) disable iff (!rst_n)
		posCode == uus_pkg::U_INC && openLoop |=>
		upr_r == {$past(poles[15:0]), 16'h0000})
		else $error("open loop revolution size wrong");
	a_step_rev: assert property (@(posedge clock) disable iff (!rst_n)
		posCode == uus_pkg::U_STEP |=> upr_r == 32'($past(poles) *
		($past(threePhase) ? 32'd6 : 32'd4)))
		else $error("step revolution size wrong");
	a_pole_rev: assert property (@(posedge clock) disable iff (!rst_n)
		posCode == uus_pkg::U_POLE |=> upr_r == $past(poles))
		else $error("pole unit size wrong");
	a_year_time: assert property (@(posedge clock) disable iff (!rst_n)
		spdTime == uus_pkg::T_YEAR |=> tsec_r == 32'd31557600)
		else $error("year length wrong");
	a_ratio_quot: assert property (@(posedge clock) disable iff (!rst_n)
		divDone && den_r != 32'h00000000 && quoFinal[47:32] == 16'h0000 |->
		prodChk <= 64'(dvdOrig_r) && 64'(dvdOrig_r) - prodChk < 64'(den_r))
		else $error("ratio quotient wrong");
	a_ratio_time: assert property (@(posedge clock) disable iff (!rst_n)
		divStart |=> calcBusy [*8]) else $error("divider stopped early");
endmodule : uus_user_unit_scaling

/* tb/uus_apb_host.sv */
// APB host model that writes and reads the unit scaling registers.
module uus_apb_host (
	input wire logic clock,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] paddr,
	output logic [31:0] pwdata,
	input wire logic pready
);
	timeunit 1ns;
	timeprecision 1ns;
	// The bus is idle at time zero.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h00000000;
		pwdata = 32'h00000000;
	end
	// One transfer; reserved bits and codes are driven as the caller gives them.
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// A released bus shows no stale address or data.
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : uus_apb_host

/* tb/uus_user_unit_scaling_test.sv */
// Self-checking bench for the user unit scaling block.
module uus_user_unit_scaling_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
	logic driveRunning, useGear, useFeed, nativeUnit, calcBusy;
	logic [31:0] paddr, pwdata, prdata, unitsPerRev, timeSeconds;
	logic [31:0] encResolution, gearRatio, feedConstant, lfsr, n, d;
	logic [64:0] notes [$]; // Error bit, expected value, mask.
	logic [64:0] note;
	int badCount, samplesChecked;
	// Stimulus tables for the unit, exponent, time and native cases.
	logic [7:0] uc [13] = '{8'h01, 8'hc1, 8'hc2, 8'h00, 8'h40, 8'h10,
		8'h41, 8'h42, 8'h43, 8'hb4, 8'hb5, 8'hac, 8'hc0};
	logic [2:0] uf [13] = '{3, 3, 3, 3, 1, 1, 1, 1, 1, 1, 4, 4, 4};
	logic [7:0] ex [6] = '{8'h06, 8'h00, 8'hfa, 8'h07, 8'hf9, 8'hff};
	logic [5:0] ev = 6'b100111;
	logic [7:0] tc [6] = '{8'h03, 8'h47, 8'h48, 8'h49, 8'h4a, 8'h05};
	logic [31:0] ts [6] = '{1, 60, 3600, 86400, 31557600, 0};
	logic [31:0] cu [4] = '{1, 0, 2, 0};
	logic [7:0] un [4] = '{8'hb5, 8'hac, 8'hac, 8'hc0};
	logic [31:0] up [4] = '{32'h00320000, 200, 300, 50};
	uus_user_unit_scaling i_uus_user_unit_scaling (.clock(clock),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .driveRunning(driveRunning), .useGear(useGear),
		.useFeed(useFeed), .nativeUnit(nativeUnit),
		.unitsPerRev(unitsPerRev), .timeSeconds(timeSeconds),
		.encResolution(encResolution), .gearRatio(gearRatio),
		.feedConstant(feedConstant), .calcBusy(calcBusy));
	uus_apb_host i_uus_apb_host (.clock(clock), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready));
	// The clock runs at 10 MHz.
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Byte address of a register index.
	function automatic logic [31:0] ad(input logic [15:0] i);
		return {14'h0000, i, 2'b00};
	endfunction : ad
	// Next value of the random sequence.
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx
	// A write, noting whether it should be refused.
	task automatic wr(input logic [15:0] i, input logic [31:0] v,
		input logic e = 1'b0);
		notes.push_back({e, 32'h0, 32'h0});
		i_uus_apb_host.xfer(1'b1, ad(i), v);
	endtask : wr
	// A read, noting the expected bits under a mask.
	task automatic rd(input logic [15:0] i, input logic [31:0] v,
		input logic [31:0] m, input logic e = 1'b0);
		notes.push_back({e, v, m});
		i_uus_apb_host.xfer(1'b0, ad(i), 32'h0);
	endtask : rd
	// Compares a settled output port with its expected value.
	task automatic chk(input logic [31:0] g, input logic [31:0] w);
		samplesChecked++;
		if (g !== w) begin
			badCount++;
			$display("unexpected at %0t: %h, want %h", $time, g, w);
		end
	endtask : chk
	// Waits until the divider has been idle for eight cycles.
	task automatic settle;
		int k;
		k = 0;
		while (k < 8) begin
			@(posedge clock);
			k = (calcBusy === 1'b0) ? k + 1 : 0;
		end
	endtask : settle
	// Prints the counts and the verdict, then ends the run.
	task automatic wrapUp;
		$display("checked %0d, mismatched %0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrapUp
	// Each finished transfer is compared with the oldest note.
	always @(posedge clock) begin
		if (psel && penable && pready && notes.size() > 0) begin
			note = notes.pop_front();
			samplesChecked++;
			if (pslverr !== note[64] ||
				(prdata & note[31:0]) !== note[63:32]) begin
				badCount++;
				$display("unexpected at %0t: %h %h, want %h %h", $time,
					pslverr, prdata & note[31:0], note[64], note[63:32]);
			end
		end
	end
	// A hang counts as a mismatch.
	initial begin
		repeat (40000) @(posedge clock);
		badCount++;
		$display("watchdog expired");
		wrapUp;
	end
	// Main sequence.
	initial begin
		rst_n = 1'b0;
		driveRunning = 1'b0;
		lfsr = 32'h9305bda5;
		badCount = 0;
		samplesChecked = 0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		settle;
		rd(16'h60a8, 32'hff410000, '1);
		rd(16'h60a9, 32'h00b44700, '1);
		wr(16'h60a8, '1);
		rd(16'h60a8, 32'hffff0000, '1);
		wr(16'h60a9, '1);
		rd(16'h60a9, 32'hffffff00, '1);
		wr(uus_pkg::IDX_STATUS, 32'h0, 1'b1);
		rd(16'h7000, 32'h0, '1, 1'b1);
		$display("test registers done");
		for (int j = 0; j < 13; j++) begin
			wr(16'h60a8, {8'h00, uc[j], 16'h0000});
			repeat (3) @(posedge clock);
			rd(uus_pkg::IDX_STATUS, {28'h0, 1'b1, uf[j]}, 32'hf);
			chk({29'h0, nativeUnit, useFeed, useGear}, {29'h0, uf[j]});
		end
		for (int j = 0; j < 6; j++) begin
			wr(16'h60a8, {ex[j], 8'h41, 16'h0000});
			repeat (3) @(posedge clock);
			rd(uus_pkg::IDX_STATUS, {27'h0, ev[j], 4'h0}, 32'h10);
			wr(16'h60a9, {8'h00, 8'hb4, tc[j], 8'h00});
			repeat (3) @(posedge clock);
			rd(uus_pkg::IDX_TSEC, ts[j], '1);
			chk(timeSeconds, ts[j]);
		end
		$display("test codes done");
		wr(16'h6206, 32'd50);
		for (int j = 0; j < 4; j++) begin
			wr(16'h6207, cu[j]);
			wr(16'h60a8, {8'h00, un[j], 16'h0000});
			settle;
			rd(uus_pkg::IDX_UPR, up[j], '1);
			chk(unitsPerRev, up[j]);
		end
		lfsr = nx(lfsr);
		n = {24'h0, lfsr[7:0]} + 32'd1;
		d = {24'h0, lfsr[15:8] | 8'h01};
		wr(16'h6200, n);
		wr(16'h6201, d);
		wr(16'h6202, d);
		wr(16'h6203, n);
		wr(16'h6204, n);
		wr(16'h6205, d);
		wr(16'h60a8, 32'h00410000);
		settle;
		rd(uus_pkg::IDX_ENCRES, (n << 16) / d, '1);
		rd(uus_pkg::IDX_GEAR, (d << 16) / n, '1);
		rd(uus_pkg::IDX_FEEDC, 32'h00010000, '1);
		chk(encResolution, (n << 16) / d);
		chk(gearRatio, (d << 16) / n);
		chk(feedConstant, 32'h00010000);
		chk({31'h0, calcBusy}, 32'h0);
		wr(16'h60a8, 32'h00010000);
		settle;
		rd(uus_pkg::IDX_FEEDC, (n << 16) / d, '1);
		chk(feedConstant, (n << 16) / d);
		wr(16'h60a8, 32'h00b50000);
		settle;
		rd(uus_pkg::IDX_GEAR, 32'h00010000, '1);
		$display("test ratios done");
		driveRunning <= 1'b1;
		wr(16'h60a8, 32'h00410000);
		repeat (3) @(posedge clock);
		rd(16'h60a8, 32'h00410000, '1);
		rd(uus_pkg::IDX_STATUS, 32'h4, 32'h7);
		driveRunning <= 1'b0;
		repeat (3) @(posedge clock);
		rd(uus_pkg::IDX_STATUS, 32'h1, 32'h7);
		$display("test deferral done");
		@(posedge clock);
		wrapUp;
	end
endmodule : uus_user_unit_scaling_test
